// [common/aow_pkg.sv]
// package: constants and types of the analog output waveform engine
package aow_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam int LVL_W      = 5;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_DIV    = 8'h08;
  localparam logic [7:0] OFF_DELAY  = 8'h0C;
  localparam logic [7:0] OFF_COUNT  = 8'h10;
  localparam logic [7:0] OFF_DATA   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_DONE   = 8'h1C;

  // ----------------------------------------------------------------
  // bit positions and reset values
  // ----------------------------------------------------------------
  localparam int CMD_START  = 0;
  localparam int CMD_STOP   = 1;
  localparam int CMD_SWUPD  = 2;
  localparam int ST_RUN     = 0;
  localparam int ST_UNDER   = 1;
  localparam int ST_EMPTY   = 2;
  localparam int ST_FULL    = 3;
  localparam int ST_ARMED   = 4;
  localparam int ST_LVL_LSB = 8;

  localparam logic [15:0] DIV_RST   = 16'h0014;
  localparam logic [15:0] DELAY_RST = 16'h0002;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FINITE     = 2'b00,
    MODE_REGEN      = 2'b01,
    MODE_FIFO_REGEN = 2'b10,
    MODE_NONREGEN   = 2'b11
  } aow_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARM   = 2'b01,
    ST_DELAY = 2'b10,
    ST_GEN   = 2'b11
  } aow_state_t;

  // control register layout, bit 0 at the bottom
  typedef struct packed {
    logic [11:0] pad;
    logic        dma_en;
    logic        fn6_out;
    logic [3:0]  pause_sel;
    logic        pause_pol;
    logic        pause_analog;
    logic        pause_en;
    logic [3:0]  trig_sel;
    logic        trig_fall;
    logic        trig_analog;
    logic        trig_en;
    logic        ext_clk;
    aow_mode_t   mode;
    logic        hw_timed;
  } aow_ctrl_t;

  typedef struct packed {
    logic [15:0] output_channel_one;
    logic [15:0] output_channel_zero;
  } aow_sample_t;

endpackage : aow_pkg

// [design/aow_engine.sv]
// analog output waveform engine with apb register access
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module aow_engine (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [7:0]         programmable_function_line_in,
  input  wire logic [6:0]         system_integration_bus_line,
  input  wire logic               internal_trigger,
  input  wire logic               analog_compare_event,
  input  wire logic               ext_sample_clock_in,
  output logic                    start_trigger_function_pin_o,
  output logic                    start_trigger_function_pin_oe,
  output logic                    output_sample_clock,
  output aow_pkg::aow_sample_t    dac_out,
  output logic                    dma_request,
  output logic                    generation_running
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    aow_pkg::aow_ctrl_t                           ctrl;
    logic [15:0]                                  div;
    logic [15:0]                                  delay;
    logic [15:0]                                  count;
    aow_pkg::aow_state_t                          fsm;
    logic [15:0]                                  tcnt;
    logic [15:0]                                  done;
    aow_pkg::aow_sample_t [aow_pkg::FIFO_DEPTH-1:0] mem;
    logic [aow_pkg::PTR_W-1:0]                    rd;
    logic [aow_pkg::PTR_W-1:0]                    wr;
    logic [aow_pkg::LVL_W-1:0]                    lvl;
    logic                                         under;
    logic                                         lock;
    aow_pkg::aow_sample_t                         out;
    logic                                         upd;
    logic                                         trg_pls;
    logic                                         trig_prev;
    logic                                         ana_prev;
    logic                                         ext_prev;
    logic [31:0]                                  rdata;
  } aow_regs_t;

  aow_regs_t r;
  aow_regs_t next_r;

  logic [15:0] src;
  logic        wr_acc;
  logic        rd_setup;
  logic        a_ctrl;
  logic        a_cmd;
  logic        a_div;
  logic        a_dly;
  logic        a_cnt;
  logic        a_data;
  logic        a_stat;
  logic        a_done;
  logic        mapped;
  logic        full;
  logic        refuse;
  logic        trig_lvl;
  logic        trig_edge;
  logic        paused;
  logic        fire;
  logic        tick;
  logic        pop;
  logic        push;
  logic        take;
  logic [15:0] divm1;

  // ----------------------------------------------------------------
  // address decode and source selection
  // ----------------------------------------------------------------
  always_comb begin
    a_ctrl = 1'b0;
    a_cmd  = 1'b0;
    a_div  = 1'b0;
    a_dly  = 1'b0;
    a_cnt  = 1'b0;
    a_data = 1'b0;
    a_stat = 1'b0;
    a_done = 1'b0;
    if (paddr == aow_pkg::OFF_CTRL) begin
      a_ctrl = 1'b1;
    end else if (paddr == aow_pkg::OFF_CMD) begin
      a_cmd = 1'b1;
    end else if (paddr == aow_pkg::OFF_DIV) begin
      a_div = 1'b1;
    end else if (paddr == aow_pkg::OFF_DELAY) begin
      a_dly = 1'b1;
    end else if (paddr == aow_pkg::OFF_COUNT) begin
      a_cnt = 1'b1;
    end else if (paddr == aow_pkg::OFF_DATA) begin
      a_data = 1'b1;
    end else if (paddr == aow_pkg::OFF_STATUS) begin
      a_stat = 1'b1;
    end else if (paddr == aow_pkg::OFF_DONE) begin
      a_done = 1'b1;
    end
  end

  assign mapped   = a_ctrl | a_cmd | a_div | a_dly | a_cnt | a_data
                  | a_stat | a_done;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign full     = r.lvl == aow_pkg::LVL_W'(aow_pkg::FIFO_DEPTH);
  // loaded FIFO-regeneration waveform is frozen
  assign refuse   = a_data & (r.lock | full);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & (~mapped | (pwrite & refuse));

  // function lines 0..7, bus lines 0..6, one internal signal
  assign src = {internal_trigger, system_integration_bus_line,
                programmable_function_line_in};
  assign trig_lvl  = src[r.ctrl.trig_sel];
  assign trig_edge = r.ctrl.trig_analog
                   ? (analog_compare_event & ~r.ana_prev)
                   : (r.ctrl.trig_fall ? (~trig_lvl & r.trig_prev)
                                       : (trig_lvl & ~r.trig_prev));
  assign paused = r.ctrl.pause_en & (r.ctrl.pause_analog
                ? analog_compare_event
                : (src[r.ctrl.pause_sel] == r.ctrl.pause_pol));
  assign divm1  = (r.div == 16'h0000) ? 16'h0000 : r.div - 16'h0001;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r           = r;
    next_r.upd       = 1'b0;
    next_r.trg_pls   = 1'b0;
    next_r.trig_prev = trig_lvl;
    next_r.ana_prev  = analog_compare_event;
    next_r.ext_prev  = ext_sample_clock_in;
    fire             = 1'b0;
    tick             = 1'b0;

    // register writes
    if (wr_acc) begin
      if (a_ctrl) begin
        next_r.ctrl = aow_pkg::aow_ctrl_t'(pwdata);
        next_r.ctrl.pad = 12'h000;
      end else if (a_div) begin
        next_r.div = pwdata[15:0];
      end else if (a_dly) begin
        next_r.delay = pwdata[15:0];
      end else if (a_cnt) begin
        next_r.count = pwdata[15:0];
      end else if (a_stat && pwdata[aow_pkg::ST_UNDER]) begin
        next_r.under = 1'b0;
      end
    end

    // sequencing
    case (r.fsm)
      aow_pkg::ST_ARM: begin
        fire = trig_edge;
      end
      aow_pkg::ST_DELAY: begin
        if (r.tcnt == 16'h0000) begin
          tick        = 1'b1;
          next_r.fsm  = aow_pkg::ST_GEN;
          next_r.tcnt = divm1;
        end else begin
          next_r.tcnt = r.tcnt - 16'h0001;
        end
      end
      aow_pkg::ST_GEN: begin
        if (r.ctrl.ext_clk) begin
          tick = ext_sample_clock_in & ~r.ext_prev;
        end else if (r.tcnt == 16'h0000) begin
          tick        = 1'b1;
          next_r.tcnt = divm1;
        end else begin
          next_r.tcnt = r.tcnt - 16'h0001;
        end
      end
      default: begin
      end
    endcase

    if (wr_acc && a_cmd && pwdata[aow_pkg::CMD_START]
        && r.fsm == aow_pkg::ST_IDLE && r.ctrl.hw_timed) begin
      next_r.done = 16'h0000;
      if (r.ctrl.trig_en) begin
        next_r.fsm = aow_pkg::ST_ARM;
      end else begin
        fire = 1'b1;
      end
    end

    if (fire) begin
      next_r.trg_pls = 1'b1;
      next_r.lock    = r.ctrl.mode == aow_pkg::MODE_FIFO_REGEN;
      if (r.ctrl.ext_clk) begin
        next_r.fsm = aow_pkg::ST_GEN;
      end else begin
        next_r.fsm  = aow_pkg::ST_DELAY;
        next_r.tcnt = (r.delay == 16'h0000) ? 16'h0000
                    : r.delay - 16'h0001;
      end
    end

    // masked sample clocks are dropped whole
    pop = (tick & ~paused)
        | (wr_acc & a_cmd & pwdata[aow_pkg::CMD_SWUPD]
           & ~r.ctrl.hw_timed);
    push = wr_acc & a_data & ~refuse;
    take = pop & (r.lvl != '0);

    if (push) begin
      next_r.mem[r.wr] = aow_pkg::aow_sample_t'(pwdata);
      next_r.wr        = r.wr + 1'b1;
    end

    if (take) begin
      next_r.out = r.mem[r.rd];
      next_r.upd = 1'b1;
      next_r.rd  = r.rd + 1'b1;
      if (r.lock) begin
        // replayed sample goes back to the tail
        next_r.mem[r.wr] = r.mem[r.rd];
        next_r.wr        = r.wr + 1'b1;
      end
      if (r.ctrl.hw_timed && r.ctrl.mode == aow_pkg::MODE_FINITE) begin
        next_r.done = r.done + 16'h0001;
        if (r.done + 16'h0001 >= r.count) begin
          next_r.fsm = aow_pkg::ST_IDLE;
        end
      end
    end else if (pop && r.ctrl.mode == aow_pkg::MODE_NONREGEN) begin
      next_r.under = 1'b1;
    end

    if (push && !(take && !r.lock)) begin
      next_r.lvl = r.lvl + 1'b1;
    end else if (!push && take && !r.lock) begin
      next_r.lvl = r.lvl - 1'b1;
    end

    // continuous modes only end here
    if (wr_acc && a_cmd && pwdata[aow_pkg::CMD_STOP]) begin
      next_r.fsm = aow_pkg::ST_IDLE;
    end
    if (next_r.fsm == aow_pkg::ST_IDLE) begin
      next_r.lock = 1'b0;
    end

    // read data captured in the setup phase
    if (rd_setup) begin
      next_r.rdata = 32'h0000_0000;
      if (a_ctrl) begin
        next_r.rdata = r.ctrl;
      end else if (a_div) begin
        next_r.rdata[15:0] = r.div;
      end else if (a_dly) begin
        next_r.rdata[15:0] = r.delay;
      end else if (a_cnt) begin
        next_r.rdata[15:0] = r.count;
      end else if (a_stat) begin
        next_r.rdata[aow_pkg::ST_RUN]   = r.fsm == aow_pkg::ST_DELAY
                                        || r.fsm == aow_pkg::ST_GEN;
        next_r.rdata[aow_pkg::ST_UNDER] = r.under;
        next_r.rdata[aow_pkg::ST_EMPTY] = r.lvl == '0;
        next_r.rdata[aow_pkg::ST_FULL]  = full;
        next_r.rdata[aow_pkg::ST_ARMED] = r.fsm == aow_pkg::ST_ARM;
        next_r.rdata[aow_pkg::ST_LVL_LSB +: aow_pkg::LVL_W] = r.lvl;
      end else if (a_done) begin
        next_r.rdata[15:0] = r.done;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.div   <= aow_pkg::DIV_RST;
      r.delay <= aow_pkg::DELAY_RST;
      r.count <= aow_pkg::COUNT_RST;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                        = r.rdata;
  assign dac_out                       = r.out;
  assign output_sample_clock           = r.upd;
  assign start_trigger_function_pin_o  = r.trg_pls;
  assign start_trigger_function_pin_oe = r.ctrl.fn6_out;
  assign generation_running            = r.fsm != aow_pkg::ST_IDLE;
  // host refill requests, silent once a frozen waveform runs
  assign dma_request = r.ctrl.dma_en & ~r.lock & ~full;

endmodule : aow_engine

// [testbench/aow_engine_properties.sv]
// checker on the ports of the waveform engine
`timescale 1ns/1ps
module aow_engine_properties (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 start_trigger_function_pin_o,
  input wire logic                 start_trigger_function_pin_oe,
  input wire logic                 output_sample_clock,
  input wire aow_pkg::aow_sample_t dac_out,
  input wire logic                 generation_running
);
  logic acc;
  assign acc = psel && penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_bad_addr: assert property (acc && !pwrite && paddr > 8'h1C
    |-> pslverr && prdata == 32'h0) else $error("unmapped read");
  a_good_read: assert property (acc && !pwrite && paddr <= 8'h1C
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped read err");
  a_wo_zero: assert property (acc && !pwrite && (paddr == aow_pkg::OFF_CMD
    || paddr == aow_pkg::OFF_DATA) |-> prdata == 32'h0)
    else $error("write-only read not zero");
  a_trig_pulse: assert property (start_trigger_function_pin_o
    |=> !start_trigger_function_pin_o) else $error("trigger pulse long");
  a_dac_moves: assert property ($changed(dac_out)
    |-> output_sample_clock) else $error("output moved without clock");
  a_stop_idles: assert property (acc && pwrite
    && paddr == aow_pkg::OFF_CMD && pwdata[1:0] == 2'h2
    |=> !generation_running) else $error("stop ignored");
  a_oe_reset: assert property ($rose(presetn)
    |-> !start_trigger_function_pin_oe) else $error("pin not input");
endmodule : aow_engine_properties

// [testbench/aow_host_mem.sv]
// host memory model serving transfers into the sample fifo
`timescale 1ns/1ps
module aow_host_mem (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic      [31:0] word
);
  logic [3:0] idx;
  // pointer moves only on an accepted fifo push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      idx <= 4'h0;
    else if (psel && penable && pwrite && pready && !pslverr
             && paddr == aow_pkg::OFF_DATA)
      idx <= idx + 4'h1;
  end
  assign word = {4'hC, 24'h0, idx};
endmodule : aow_host_mem

// [testbench/aow_engine_tb_top.sv]
// self-checking testbench of the waveform engine
`timescale 1ns/1ps
module aow_engine_tb_top;
  logic                 pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, word, rd;
  logic                 pready, pslverr, cmp_ev;
  logic [6:0]           bus_line;
  logic                 pin_o, pin_oe, samp_clk, dma_request, running;
  logic                 ext_clk, int_trig;
  logic [7:0]           fn_line;
  aow_pkg::aow_sample_t dac_out;
  int                   errors, comparisons, cyc, npin, trig_cyc;
  int                   ts[$];
  logic [31:0]          sv[$];

  always #25 pclk = ~pclk;

  aow_engine uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .programmable_function_line_in(fn_line),
    .system_integration_bus_line(bus_line), .internal_trigger(int_trig),
    .analog_compare_event(cmp_ev), .ext_sample_clock_in(ext_clk),
    .start_trigger_function_pin_o(pin_o),
    .start_trigger_function_pin_oe(pin_oe),
    .output_sample_clock(samp_clk), .dac_out(dac_out),
    .dma_request(dma_request), .generation_running(running));

  aow_host_mem host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .word(word));

  // settled outputs, sampled mid-cycle
  always @(negedge pclk) begin
    cyc++;
    if (pin_o === 1'b1) begin
      npin++;
      trig_cyc = cyc;
    end
    if (samp_clk === 1'b1) begin
      ts.push_back(cyc);
      sv.push_back(dac_out);
    end
  end

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rst();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    ts.delete();
    sv.delete();
    npin = 0;
  endtask : rst

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rst();
    chk("pin oe", pin_oe, 32'h0);
    apb(1'b0, aow_pkg::OFF_DELAY, 32'h0);
    chk("delay", rd, 32'h2);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", err, 32'h1);
    $display("done reset");
  endtask : t_reset

  task automatic t_soft();
    rst();
    apb(1'b1, aow_pkg::OFF_DATA, 32'h1234ABCD);
    apb(1'b1, aow_pkg::OFF_CMD, 32'h4);
    repeat (4) @(posedge pclk);
    chk("sw updates", ts.size(), 32'h1);
    chk("sw value", sv[0], 32'h1234ABCD);
    $display("done soft");
  endtask : t_soft

  task automatic t_finite();
    int n;
    rst();
    apb(1'b1, aow_pkg::OFF_CTRL, 32'h000C0001);
    apb(1'b1, aow_pkg::OFF_DIV, 32'h4);
    apb(1'b1, aow_pkg::OFF_COUNT, 32'h3);
    n = 0;
    #1;
    while (dma_request === 1'b1 && n < 20) begin
      apb(1'b1, aow_pkg::OFF_DATA, word);
      n++;
      #1;
    end
    chk("fill", n, aow_pkg::FIFO_DEPTH);
    chk("pin oe", pin_oe, 32'h1);
    apb(1'b1, aow_pkg::OFF_CMD, 32'h1);
    repeat (40) @(posedge pclk);
    chk("count", ts.size(), 32'h3);
    for (int i = 0; i < 3; i++)
      chk("sample", sv[i], {28'hC000000, i[3:0]});
    chk("first delay", ts[0] - trig_cyc, 32'h2);
    chk("period", ts[1] - ts[0], 32'h4);
    chk("pulses", npin, 32'h1);
    chk("halted", running, 32'h0);
    $display("done finite");
  endtask : t_finite

  task automatic t_nonregen();
    rst();
    apb(1'b1, aow_pkg::OFF_CTRL, 32'h7);
    apb(1'b1, aow_pkg::OFF_CMD, 32'h1);
    repeat (50) @(posedge pclk);
    chk("running", running, 32'h1);
    apb(1'b1, aow_pkg::OFF_CMD, 32'h2);
    apb(1'b0, aow_pkg::OFF_STATUS, 32'h0);
    chk("underflow", rd[1], 32'h1);
    apb(1'b1, aow_pkg::OFF_STATUS, 32'h2);
    apb(1'b0, aow_pkg::OFF_STATUS, 32'h0);
    chk("cleared", rd[1], 32'h0);
    $display("done nonregen");
  endtask : t_nonregen

  task automatic t_fregen();
    rst();
    apb(1'b1, aow_pkg::OFF_CTRL, 32'h00080005);
    apb(1'b1, aow_pkg::OFF_DIV, 32'h4);
    apb(1'b1, aow_pkg::OFF_DATA, 32'h00000011);
    apb(1'b1, aow_pkg::OFF_DATA, 32'h00000022);
    apb(1'b1, aow_pkg::OFF_CMD, 32'h1);
    repeat (3) @(posedge pclk);
    #1;
    chk("no dma", dma_request, 32'h0);
    apb(1'b1, aow_pkg::OFF_DATA, 32'h00000033);
    chk("push refused", err, 32'h1);
    repeat (20) @(posedge pclk);
    chk("replay a", sv[2], 32'h00000011);
    chk("replay b", sv[3], 32'h00000022);
    $display("done fifo regen");
  endtask : t_fregen

  // one external sample clock pulse, then a quiet gap
  task automatic pulse();
    ext_clk <= 1'b1;
    @(posedge pclk);
    ext_clk <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  task automatic t_pause();
    rst();
    apb(1'b1, aow_pkg::OFF_CTRL, 32'h0002680B);
    apb(1'b1, aow_pkg::OFF_DATA, 32'h0000000A);
    apb(1'b1, aow_pkg::OFF_DATA, 32'h0000000B);
    apb(1'b1, aow_pkg::OFF_CMD, 32'h1);
    pulse();
    bus_line <= 7'h02;
    pulse();
    bus_line <= 7'h00;
    pulse();
    chk("ext updates", ts.size(), 32'h2);
    chk("first ext", sv[0], 32'h0000000A);
    chk("after pause", sv[1], 32'h0000000B);
    chk("regen runs", running, 32'h1);
    $display("done pause");
  endtask : t_pause

  task automatic t_trig();
    logic [31:0] cfg [5] = '{32'h00040411, 32'h00040451, 32'h00040031,
                             32'h00040791, 32'h00040111};
    for (int m = 0; m < 5; m++) begin
      rst();
      bus_line <= (m == 1) ? 7'h01 : 7'h00;
      apb(1'b1, aow_pkg::OFF_CTRL, cfg[m]);
      apb(1'b1, aow_pkg::OFF_CMD, 32'h1);
      repeat (5) @(posedge pclk);
      chk("armed", npin, 32'h0);
      if (m == 2)
        cmp_ev <= 1'b1;
      else if (m == 3)
        int_trig <= 1'b1;
      else if (m == 4)
        fn_line <= 8'h04;
      else
        bus_line <= bus_line ^ 7'h01;
      repeat (5) @(posedge pclk);
      chk("fired", npin, 32'h1);
      chk("started", running, 32'h1);
      cmp_ev <= 1'b0;
      int_trig <= 1'b0;
      fn_line <= 8'h00;
    end
    $display("done triggers");
  endtask : t_trig

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bus_line = 7'h00;
    cmp_ev = 1'b0;
    {ext_clk, int_trig, fn_line} = '0;
    {errors, comparisons, cyc, npin, trig_cyc} = '0;
    t_reset();
    t_soft();
    t_finite();
    t_nonregen();
    t_fregen();
    t_pause();
    t_trig();
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    end_of_test();
  end
endmodule : aow_engine_tb_top

bind aow_engine aow_engine_properties chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .start_trigger_function_pin_o(start_trigger_function_pin_o),
  .start_trigger_function_pin_oe(start_trigger_function_pin_oe),
  .output_sample_clock(output_sample_clock), .dac_out(dac_out),
  .generation_running(generation_running));
